// >>> core/dcr_control_regs.sv
// How it works
// - override: forced bit 0=50Hz, 1=60Hz
// - no override: standard from detected rate
// - sample rate 0 square, 1 601
// - reference 0=26.8MHz, 1=24.576MHz
// - loop speed: very fast, fast, VCR, TV
// - vertical end line 10/10.5 or 9/9.5
// - power down stops all but bus, clocks
// - channel select maps composite, s-video, component
// - gain freeze holds gain, register reads it
// - overflow mode lets overflow reduce gain
// - edge align picks vertical edge positions
// - gain target 68 or 54 codes
// - manual loop enable selects manual tracking
// - manual freq: freeze, track, nominal
// - manual phase bit enables phase tracking
// - peak bit acts only when enabled
// - vertical free run ignores input
// - general port bit drives or reads pin
// - narrowing bit filters luma to 1MHz
// - sync pin direction: 0 out, 1 in
// - input source analog, digital cbycr, cvbs
// - clock select internal or pixel pin
// - embedded sync select in digital cbycr
`timescale 1ns/1ps
`default_nettype none

module dcr_control_regs #(
  parameter logic [7:0] GAIN_RESET = dcr_pkg::DCR_RST_AGC
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  // host register port
  input  wire logic [7:0]  reg_index_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // status from the decoder core
  input  wire logic        detected_rate_60_i,
  input  wire logic [7:0]  live_gain_i,
  input  wire logic        hsync_gen_i,
  input  wire logic        vsync_gen_i,
  input  wire logic        pixel_tick_gen_i,
  input  wire logic [2:0]  port_a_function_i,
  input  wire logic        port_a_direction_i,
  // general io pin
  input  wire logic        general_io_pin_i,
  output logic             general_io_pin_o,
  output logic             general_io_pin_oe_o,
  // horizontal sync one pin
  input  wire logic        horizontal_sync_one_pin_i,
  output logic             horizontal_sync_one_pin_o,
  output logic             horizontal_sync_one_pin_oe_o,
  // vertical sync pin
  input  wire logic        vertical_sync_pin_i,
  output logic             vertical_sync_pin_o,
  output logic             vertical_sync_pin_oe_o,
  // pixel timing pin
  output logic             pixel_timing_pin_o,
  output logic             pixel_timing_pin_oe_o,
  // decoded controls to the core
  output logic             core_enable_o,
  output logic             field_rate_60_o,
  output logic             sample_rate_601_o,
  output logic             ref_freq_24m_o,
  output logic      [1:0]  hloop_speed_o,
  output logic             vertical_end_early_o,
  output logic      [2:0]  luma_select_o,
  output logic      [2:0]  chroma_select_o,
  output logic             svideo_mode_o,
  output logic             component_mode_o,
  output logic             gain_freeze_o,
  output logic      [7:0]  gain_value_o,
  output logic             gain_overflow_reduce_o,
  output logic             vertical_edge_align_o,
  output logic      [6:0]  gain_target_o,
  output dcr_pkg::dcr_hfreq_t hfreq_mode_o,
  output logic             hphase_track_o,
  output logic             hphase_from_hs1_o,
  output logic             clamp_sync_tip_o,
  output logic             vertical_free_run_o,
  output logic             luma_narrow_filter_o,
  output logic      [1:0]  input_source_o,
  output logic             external_pixel_timing_o,
  output logic             use_embedded_sync_o,
  output logic             hs1_in_o,
  output logic             vs_in_o
);
  import dcr_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] gn;
    logic [7:0] hl;
    logic [7:0] sc;
    logic [7:0] agc;
    logic [7:0] rdata;
    logic [2:0] gp_sync;
    logic [2:0] hs_sync;
    logic [2:0] vs_sync;
    logic       gp_pin;
    logic       gp_oe;
    logic       hs_out;
    logic       hs_oe;
    logic       vs_out;
    logic       vs_oe;
    logic       pt_out;
    logic       pt_oe;
    logic       core_en;
    logic       rate60;
    logic       sr601;
    logic       ref24;
    logic [1:0] hspeed;
    logic       vend;
    logic [2:0] luma_sel;
    logic [2:0] chroma_sel;
    logic       svideo;
    logic       component;
    logic       frz;
    logic [7:0] gain_val;
    logic       ovf;
    logic       vertical_edge_align;
    logic [6:0] target;
    dcr_hfreq_t hfreq;
    logic       hphase;
    logic       hph_hs1;
    logic       clamp_tip;
    logic       vfree;
    logic       narrow;
    logic [1:0] src;
    logic       extclk;
    logic       embsync;
    logic       hs_in;
    logic       vs_in;
    logic       gp_in;
  } dcr_state_t;

  dcr_state_t state_ff;
  dcr_state_t nxt_state;

  // ---------------------------------------------------------------
  // channel decode
  // ---------------------------------------------------------------
  // returns {luma[2:0], chroma[2:0], svideo, component}; reserved
  // codes select nothing so no input is switched onto the adc
  function automatic logic [7:0] dcr_chan_decode(input logic [3:0] ch);
    logic [7:0] r;
    r = 8'h00;
    case (ch)
      4'h0: r = 8'h40;
      4'h1: r = 8'h80;
      4'h2: r = 8'h00 | 8'h00 | 8'h00 | 8'h00 | 8'h00 | 8'h00 | 8'h00 | 8'h00;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       pd;
    logic       gp_mode;
    logic       gp_in;
    logic [3:0] ch;
    logic [1:0] hf;
    nxt_state = state_ff;
    pd        = state_ff.fmt[DCR_FMT_POWER_DOWN];
    gp_mode   = (port_a_function_i == DCR_GENERAL_IO_PIN_GPIO);
    gp_in     = state_ff.gp_in;
    ch        = state_ff.gn[DCR_GN_CHAN_HI:DCR_GN_CHAN_LO];
    hf        = state_ff.hl[DCR_HL_FREQ_HI:DCR_HL_FREQ_LO];

    // pin synchronisers, change taken once stages two and three agree
    nxt_state.gp_sync = {state_ff.gp_sync[1:0], general_io_pin_i};
    nxt_state.hs_sync = {state_ff.hs_sync[1:0], horizontal_sync_one_pin_i};
    nxt_state.vs_sync = {state_ff.vs_sync[1:0], vertical_sync_pin_i};
    if (state_ff.hs_sync[2] == state_ff.hs_sync[1]) begin
      nxt_state.hs_in = state_ff.hs_sync[2];
    end
    if (state_ff.vs_sync[2] == state_ff.vs_sync[1]) begin
      nxt_state.vs_in = state_ff.vs_sync[2];
    end
    if (state_ff.gp_sync[2] == state_ff.gp_sync[1]) begin
      nxt_state.gp_in = state_ff.gp_sync[2];
    end

    // register writes; reserved bits stay zero
    if (reg_wr_i) begin
      case (reg_index_i)
        DCR_IDX_FORMAT: nxt_state.fmt = reg_wdata_i;
        DCR_IDX_GAIN:   nxt_state.gn  = reg_wdata_i;
        DCR_IDX_HLOOP:  nxt_state.hl  = reg_wdata_i & DCR_MASK_HLOOP;
        DCR_IDX_SOURCE: nxt_state.sc  = reg_wdata_i & DCR_MASK_SOURCE;
        DCR_IDX_AGC:    nxt_state.agc = reg_wdata_i;
        default: begin
        end
      endcase
    end

    // freezing captures the live gain unless software writes it now
    if (!state_ff.gn[DCR_GN_FREEZE] && nxt_state.gn[DCR_GN_FREEZE] &&
        !(reg_wr_i && reg_index_i == DCR_IDX_AGC)) begin
      nxt_state.agc = live_gain_i;
    end

    // register reads, one cycle after the strobe; unmapped reads zero
    if (reg_rd_i) begin
      case (reg_index_i)
        DCR_IDX_FORMAT: nxt_state.rdata = state_ff.fmt;
        DCR_IDX_GAIN:   nxt_state.rdata = state_ff.gn;
        DCR_IDX_HLOOP:  nxt_state.rdata = state_ff.hl;
        DCR_IDX_SOURCE: begin
          nxt_state.rdata = state_ff.sc;
          if (gp_mode && !port_a_direction_i) begin
            nxt_state.rdata[DCR_SC_GPBIT] = gp_in;
          end
        end
        DCR_IDX_AGC: begin
          nxt_state.rdata = state_ff.gn[DCR_GN_FREEZE] ? state_ff.agc
                                                       : live_gain_i;
        end
        default: nxt_state.rdata = 8'h00;
      endcase
    end

    // general io pin: only in gpio function, only when driving
    nxt_state.gp_oe  = gp_mode && port_a_direction_i;
    nxt_state.gp_pin = state_ff.sc[DCR_SC_GPBIT];

    // sync pins
    nxt_state.hs_oe  = !state_ff.sc[DCR_SC_SYNCDIR];
    nxt_state.vs_oe  = !state_ff.sc[DCR_SC_SYNCDIR];
    nxt_state.hs_out = hsync_gen_i & !pd;
    nxt_state.vs_out = vsync_gen_i & !pd;

    // pixel timing pin turns input when the clock comes from outside
    nxt_state.extclk = state_ff.sc[DCR_SC_EXTCLK];
    nxt_state.pt_oe  = !state_ff.sc[DCR_SC_EXTCLK];
    nxt_state.pt_out = pixel_tick_gen_i;

    // core enable; clock rate inputs freeze while powered down
    nxt_state.core_en = !pd;
    if (!pd) begin
      nxt_state.sr601 = state_ff.fmt[DCR_FMT_SAMPLE_RATE];
      nxt_state.ref24 = state_ff.fmt[DCR_FMT_REF_FREQ];
      nxt_state.rate60 = state_ff.fmt[DCR_FMT_OVERRIDE]
                       ? state_ff.fmt[DCR_FMT_FORCED_RATE]
                       : detected_rate_60_i;
    end

    // timing controls
    nxt_state.hspeed = state_ff.fmt[DCR_FMT_HSPEED_HI:DCR_FMT_HSPEED_LO];
    nxt_state.vend   = state_ff.fmt[DCR_FMT_VEND];
    nxt_state.vertical_edge_align = state_ff.gn[DCR_GN_VERTICAL_EDGE_ALIGN];
    nxt_state.vfree  = state_ff.hl[DCR_HL_VFREE];

    // input channel routing
    nxt_state.luma_sel   = 3'h0;
    nxt_state.chroma_sel = 3'h0;
    nxt_state.svideo     = 1'b0;
    nxt_state.component  = 1'b0;
    case (ch)
      4'h0, 4'h1, 4'h2: nxt_state.luma_sel = 3'h1 << ch[1:0];
      4'h4, 4'h5, 4'h6: nxt_state.chroma_sel = 3'h1 << ch[1:0];
      4'h8, 4'h9, 4'hA: begin
        nxt_state.luma_sel   = 3'h1 << ch[1:0];
        nxt_state.chroma_sel = 3'h1 << ch[1:0];
        nxt_state.svideo     = 1'b1;
      end
      DCR_CH_COMPONENT: begin
        nxt_state.luma_sel   = 3'h4;
        nxt_state.chroma_sel = 3'h6;
        nxt_state.component  = 1'b1;
      end
      default: begin
      end
    endcase

    // gain loop controls
    nxt_state.frz      = state_ff.gn[DCR_GN_FREEZE];
    nxt_state.gain_val = state_ff.gn[DCR_GN_FREEZE] ? state_ff.agc
                                                    : live_gain_i;
    nxt_state.ovf      = state_ff.gn[DCR_GN_OVERFLOW];
    nxt_state.target   = state_ff.gn[DCR_GN_REFSEL] ? DCR_AGC_TARGET_REDUCED
                                                    : DCR_AGC_TARGET_NORMAL;
    nxt_state.clamp_tip = state_ff.hl[DCR_HL_PEAK_EN] &
                          state_ff.hl[DCR_HL_PEAK];

    // horizontal tracking
    if (!state_ff.hl[DCR_HL_MANUAL]) begin
      nxt_state.hfreq  = DCR_HF_AUTO;
      nxt_state.hphase = 1'b1;
    end else begin
      case (hf)
        2'h0:    nxt_state.hfreq = DCR_HF_FREEZE;
        2'h1:    nxt_state.hfreq = DCR_HF_TRACK;
        default: nxt_state.hfreq = DCR_HF_NOMINAL;
      endcase
      nxt_state.hphase = state_ff.hl[DCR_HL_PHASE];
    end
    // slave mode: sync pins are inputs, phase follows hs1
    nxt_state.hph_hs1 = state_ff.sc[DCR_SC_SYNCDIR];

    // source selection
    nxt_state.narrow  = state_ff.sc[DCR_SC_NARROW];
    nxt_state.src     = state_ff.sc[DCR_SC_SRC_HI:DCR_SC_SRC_LO];
    nxt_state.embsync = (state_ff.sc[DCR_SC_SRC_HI:DCR_SC_SRC_LO] == DCR_SRC_DIG_CBYCR) &&
                        state_ff.sc[DCR_SC_EMBSYNC];
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // reset loads defaults and the derived register controls that follow from them
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff        <= '0;
      state_ff.fmt    <= DCR_RST_FORMAT;
      state_ff.gn     <= DCR_RST_GAIN;
      state_ff.hl     <= DCR_RST_HLOOP;
      state_ff.sc     <= DCR_RST_SOURCE;
      state_ff.agc    <= GAIN_RESET;
      state_ff.hfreq  <= DCR_HF_AUTO;
      state_ff.hphase <= 1'b1;
      state_ff.hs_oe  <= 1'b1;
      state_ff.vs_oe  <= 1'b1;
      state_ff.pt_oe  <= 1'b1;
      state_ff.core_en <= 1'b1;
      state_ff.sr601  <= 1'b1;
      state_ff.ref24  <= 1'b1;
      state_ff.hspeed <= 2'h2;
      state_ff.ovf    <= 1'b1;
      state_ff.luma_sel <= 3'h1;
      state_ff.target <= DCR_AGC_TARGET_NORMAL;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign reg_rdata_o                  = state_ff.rdata;
  assign general_io_pin_o             = state_ff.gp_pin;
  assign general_io_pin_oe_o          = state_ff.gp_oe;
  assign horizontal_sync_one_pin_o    = state_ff.hs_out;
  assign horizontal_sync_one_pin_oe_o = state_ff.hs_oe;
  assign vertical_sync_pin_o          = state_ff.vs_out;
  assign vertical_sync_pin_oe_o       = state_ff.vs_oe;
  assign pixel_timing_pin_o           = state_ff.pt_out;
  assign pixel_timing_pin_oe_o        = state_ff.pt_oe;
  assign core_enable_o                = state_ff.core_en;
  assign field_rate_60_o              = state_ff.rate60;
  assign sample_rate_601_o            = state_ff.sr601;
  assign ref_freq_24m_o               = state_ff.ref24;
  assign hloop_speed_o                = state_ff.hspeed;
  assign vertical_end_early_o         = state_ff.vend;
  assign luma_select_o                = state_ff.luma_sel;
  assign chroma_select_o              = state_ff.chroma_sel;
  assign svideo_mode_o                = state_ff.svideo;
  assign component_mode_o             = state_ff.component;
  assign gain_freeze_o                = state_ff.frz;
  assign gain_value_o                 = state_ff.gain_val;
  assign gain_overflow_reduce_o       = state_ff.ovf;
  assign vertical_edge_align_o        = state_ff.vertical_edge_align;
  assign gain_target_o                = state_ff.target;
  assign hfreq_mode_o                 = state_ff.hfreq;
  assign hphase_track_o               = state_ff.hphase;
  assign hphase_from_hs1_o            = state_ff.hph_hs1;
  assign clamp_sync_tip_o             = state_ff.clamp_tip;
  assign vertical_free_run_o          = state_ff.vfree;
  assign luma_narrow_filter_o         = state_ff.narrow;
  assign input_source_o               = state_ff.src;
  assign external_pixel_timing_o      = state_ff.extclk;
  assign use_embedded_sync_o          = state_ff.embsync;
  assign hs1_in_o                     = state_ff.hs_in;
  assign vs_in_o                      = state_ff.vs_in;

endmodule

`default_nettype wire

// >>> core/dcr_pkg.sv
package dcr_pkg;

  // ---------------------------------------------------------------
  // register indices
  // ---------------------------------------------------------------
  localparam logic [7:0] DCR_IDX_FORMAT = 8'h01;
  localparam logic [7:0] DCR_IDX_GAIN   = 8'h02;
  localparam logic [7:0] DCR_IDX_HLOOP  = 8'h03;
  localparam logic [7:0] DCR_IDX_SOURCE = 8'h04;
  localparam logic [7:0] DCR_IDX_AGC    = 8'h0B;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] DCR_RST_FORMAT = 8'h2C;
  localparam logic [7:0] DCR_RST_GAIN   = 8'h20;
  localparam logic [7:0] DCR_RST_HLOOP  = 8'h00;
  localparam logic [7:0] DCR_RST_SOURCE = 8'h00;
  localparam logic [7:0] DCR_RST_AGC    = 8'h00;

  // reserved bits read as zero
  localparam logic [7:0] DCR_MASK_HLOOP  = 8'hDF;
  localparam logic [7:0] DCR_MASK_SOURCE = 8'hBF;

  // ---------------------------------------------------------------
  // format_timing_control fields
  // ---------------------------------------------------------------
  localparam int DCR_FMT_FORCED_RATE = 0;
  localparam int DCR_FMT_OVERRIDE    = 1;
  localparam int DCR_FMT_SAMPLE_RATE = 2;
  localparam int DCR_FMT_REF_FREQ    = 3;
  localparam int DCR_FMT_HSPEED_LO   = 4;
  localparam int DCR_FMT_HSPEED_HI   = 5;
  localparam int DCR_FMT_VEND        = 6;
  localparam int DCR_FMT_POWER_DOWN  = 7;

  // input_gain_control fields
  localparam int DCR_GN_CHAN_LO  = 0;
  localparam int DCR_GN_CHAN_HI  = 3;
  localparam int DCR_GN_FREEZE   = 4;
  localparam int DCR_GN_OVERFLOW = 5;
  localparam int DCR_GN_VERTICAL_EDGE_ALIGN   = 6;
  localparam int DCR_GN_REFSEL   = 7;

  // hloop_test_control fields
  localparam int DCR_HL_MANUAL   = 0;
  localparam int DCR_HL_FREQ_LO  = 1;
  localparam int DCR_HL_FREQ_HI  = 2;
  localparam int DCR_HL_PHASE    = 3;
  localparam int DCR_HL_PEAK     = 4;
  localparam int DCR_HL_PEAK_EN  = 6;
  localparam int DCR_HL_VFREE    = 7;

  // source_clock_control fields
  localparam int DCR_SC_GPBIT    = 0;
  localparam int DCR_SC_NARROW   = 1;
  localparam int DCR_SC_SYNCDIR  = 2;
  localparam int DCR_SC_SRC_LO   = 3;
  localparam int DCR_SC_SRC_HI   = 4;
  localparam int DCR_SC_EXTCLK   = 5;
  localparam int DCR_SC_EMBSYNC  = 7;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] DCR_SRC_ANALOG    = 2'h0;
  localparam logic [1:0] DCR_SRC_DIG_CBYCR = 2'h1;
  localparam logic [1:0] DCR_SRC_DIG_CVBS  = 2'h3;
  localparam logic [2:0] DCR_GENERAL_IO_PIN_GPIO    = 3'h7;
  localparam logic [3:0] DCR_CH_COMPONENT  = 4'hF;

  // gain target in adc codes
  localparam logic [6:0] DCR_AGC_TARGET_NORMAL  = 7'h44;
  localparam logic [6:0] DCR_AGC_TARGET_REDUCED = 7'h36;

  // horizontal frequency tracking modes
  typedef enum logic [3:0] {
    DCR_HF_AUTO    = 4'b0001,
    DCR_HF_FREEZE  = 4'b0010,
    DCR_HF_TRACK   = 4'b0100,
    DCR_HF_NOMINAL = 4'b1000
  } dcr_hfreq_t;

endpackage

// >>> core/unused_note.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> testbench/dcr_control_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module dcr_control_regs_monitor (
  // clock, reset and register port
  input wire logic       clock_i,
  input wire logic       rstn_i,
  input wire logic [7:0] reg_index_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // pins and decoded controls
  input wire logic [2:0] port_a_function_i,
  input wire logic       port_a_direction_i,
  input wire logic       general_io_pin_oe_o,
  input wire logic       horizontal_sync_one_pin_oe_o,
  input wire logic       vertical_sync_pin_oe_o,
  input wire logic       pixel_timing_pin_oe_o,
  input wire logic       core_enable_o,
  input wire logic [6:0] gain_target_o,
  input wire dcr_pkg::dcr_hfreq_t hfreq_mode_o,
  input wire logic [1:0] input_source_o,
  input wire logic       use_embedded_sync_o
);
  import dcr_pkg::*;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  // write decodes; checks look three edges on so either settle point passes
  logic wf, wg, wh, ws;
  assign wf = reg_wr_i && reg_index_i == DCR_IDX_FORMAT;
  assign wg = reg_wr_i && reg_index_i == DCR_IDX_GAIN;
  assign wh = reg_wr_i && reg_index_i == DCR_IDX_HLOOP;
  assign ws = reg_wr_i && reg_index_i == DCR_IDX_SOURCE;

  // --------------------------------
  // assertions
  // --------------------------------
  property p_power; wf ##3 1 |-> core_enable_o == !$past(reg_wdata_i[7], 3); endproperty
  a_power: assert property (p_power) else $error("core enable wrong");
  property p_sync_dir;
    ws ##3 1 |-> horizontal_sync_one_pin_oe_o == !$past(reg_wdata_i[2], 3)
                 && vertical_sync_pin_oe_o == !$past(reg_wdata_i[2], 3);
  endproperty
  a_sync_dir: assert property (p_sync_dir) else $error("sync pin enable wrong");
  property p_clk_sel; ws ##3 1 |-> pixel_timing_pin_oe_o == !$past(reg_wdata_i[5], 3); endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("pixel pin enable wrong");
  property p_target;
    wg ##3 1 |-> gain_target_o == ($past(reg_wdata_i[7], 3) ? 7'h36 : 7'h44);
  endproperty
  a_target: assert property (p_target) else $error("gain target wrong");
  property p_auto; wh && !reg_wdata_i[0] ##3 1 |-> hfreq_mode_o == DCR_HF_AUTO; endproperty
  a_auto: assert property (p_auto) else $error("tracking not automatic");
  property p_embedded; use_embedded_sync_o |-> input_source_o == 2'h1; endproperty
  a_embedded: assert property (p_embedded) else $error("embedded sync off mode");
  property p_gpio_oe;
    (port_a_function_i == 3'h7 && port_a_direction_i) [*3] |-> general_io_pin_oe_o;
  endproperty
  a_gpio_oe: assert property (p_gpio_oe) else $error("port pin not driven");
  property p_unmapped; reg_rd_i && reg_index_i > DCR_IDX_AGC |=> reg_rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule

bind dcr_control_regs dcr_control_regs_monitor u_dcr_control_regs_monitor (.*);

`default_nettype wire

// >>> testbench/tb_dcr_control_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_dcr_control_regs;
  import dcr_pkg::*;
  // --------------------------------
  // design inputs and outputs
  // --------------------------------
  logic clock_i = 0, rstn_i = 0, reg_wr_i = 0, reg_rd_i = 0, detected_rate_60_i = 0;
  logic [7:0] reg_index_i = 0, reg_wdata_i = 0, live_gain_i = 0, reg_rdata_o, gain_value_o;
  logic hsync_gen_i = 1, vsync_gen_i = 1, pixel_tick_gen_i = 0, port_a_direction_i = 0;
  logic general_io_pin_i = 0, horizontal_sync_one_pin_i = 0, vertical_sync_pin_i = 0;
  logic [2:0] port_a_function_i = 0, luma_select_o, chroma_select_o;
  logic [6:0] gain_target_o;
  logic [1:0] hloop_speed_o, input_source_o;
  dcr_hfreq_t hfreq_mode_o;
  logic general_io_pin_o, general_io_pin_oe_o, horizontal_sync_one_pin_o;
  logic horizontal_sync_one_pin_oe_o, vertical_sync_pin_o, vertical_sync_pin_oe_o;
  logic pixel_timing_pin_o, pixel_timing_pin_oe_o, core_enable_o, field_rate_60_o;
  logic sample_rate_601_o, ref_freq_24m_o, vertical_end_early_o, svideo_mode_o;
  logic component_mode_o, gain_freeze_o, gain_overflow_reduce_o, vertical_edge_align_o;
  logic hphase_track_o, hphase_from_hs1_o, clamp_sync_tip_o, vertical_free_run_o;
  logic luma_narrow_filter_o, external_pixel_timing_o, use_embedded_sync_o, hs1_in_o, vs_in_o;
  // bench state
  int miscompares = 0, checks_done = 0, cycles = 0;
  logic [31:0] seed = 32'h0000FE64, v;
  logic [7:0] exp_q[$];
  logic rd_seen = 0;
  wire [7:0] pd_view = {core_enable_o, field_rate_60_o, sample_rate_601_o, ref_freq_24m_o,
                        horizontal_sync_one_pin_o, vertical_sync_pin_o, pixel_timing_pin_oe_o,
                        pixel_timing_pin_o};

  dcr_control_regs u_dcr_control_regs (.*);

  initial forever #5 clock_i = ~clock_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic wrap_up();
    if (miscompares == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one-cycle strobes; the gap cycle keeps a task from re-driving at its own edge
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clock_i);
    reg_wr_i <= 1;
    reg_index_i <= idx;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_wr_i <= 0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    @(posedge clock_i);
    reg_rd_i <= 1;
    reg_index_i <= idx;
    exp_q.push_back(e);
    @(posedge clock_i);
    reg_rd_i <= 0;
  endtask

  // decoded controls except gain value, hs1 phase select and the hs1/vs pin inputs against four register values
  task automatic chk_all(input logic [7:0] f, input logic [7:0] g, input logic [7:0] h,
                         input logic [7:0] s);
    logic [7:0] ce;
    dcr_hfreq_t he;
    ce = 8'h00;
    if (g[3:0] inside {0, 1, 2}) ce[5:3] = 3'b001 << g[1:0];
    if (g[3:0] inside {4, 5, 6}) ce[2:0] = 3'b001 << g[1:0];
    if (g[3:0] inside {8, 9, 10}) ce = {2'b10, 3'b001 << g[1:0], 3'b001 << g[1:0]};
    if (g[3:0] == 4'hF) ce = 8'b01_100_110;
    he = !h[0] ? DCR_HF_AUTO : h[2] ? DCR_HF_NOMINAL : h[1] ? DCR_HF_TRACK : DCR_HF_FREEZE;
    chk({field_rate_60_o, sample_rate_601_o,
         ref_freq_24m_o, hloop_speed_o, vertical_end_early_o, core_enable_o, 1'b0},
        {f[1] ? f[0] : detected_rate_60_i, f[2], f[3], f[5:4], f[6], !f[7], 1'b0});
    chk({svideo_mode_o, component_mode_o, luma_select_o, chroma_select_o}, ce);
    chk({gain_target_o, vertical_edge_align_o}, {g[7] ? 7'h36 : 7'h44, g[6]});
    chk({gain_freeze_o, gain_overflow_reduce_o, 6'h00}, {g[4], g[5], 6'h00});
    chk({hfreq_mode_o, hphase_track_o,
         clamp_sync_tip_o, vertical_free_run_o, 1'b0},
        {he, h[0] ? h[3] : 1'b1, h[6] & h[4], h[7], 1'b0});
    chk({luma_narrow_filter_o, input_source_o,
         external_pixel_timing_o, pixel_timing_pin_oe_o, horizontal_sync_one_pin_oe_o,
         vertical_sync_pin_oe_o, use_embedded_sync_o},
        {s[1], s[4:3], s[5], !s[5], !s[2], !s[2], s[4:3] == 2'h1 && s[7]});
  endtask

  // read answers come one edge after the strobe; oldest note first
  always @(posedge clock_i) begin
    cycles++;
    rd_seen <= reg_rd_i;
    if (rd_seen && exp_q.size() > 0) chk(reg_rdata_o, exp_q.pop_front());
    if (cycles == 5000) begin
      miscompares++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clock_i);
    rstn_i <= 1;
    repeat (2) @(posedge clock_i);
    chk_all(8'h2C, 8'h20, 8'h00, 8'h00);
    rd(8'h01, 8'h2C);
    rd(8'h02, 8'h20);
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h00);
    for (int i = 0; i < 16; i++) begin
      v = rnd();
      detected_rate_60_i <= v[8];
      live_gain_i <= v[11:4];
      wr(8'h01, {1'b0, v[6:0]});
      wr(8'h02, {v[15:12], i[3:0]});
      wr(8'h03, v[23:16]);
      wr(8'h04, v[31:24]);
      repeat (3) @(posedge clock_i);
      chk_all({1'b0, v[6:0]}, {v[15:12], i[3:0]}, v[23:16], v[31:24]);
      rd(8'h01, {1'b0, v[6:0]});
      rd(8'h02, {v[15:12], i[3:0]});
      rd(8'h03, v[23:16] & 8'hDF);
      rd(8'h04, v[31:24] & 8'hBF);
    end
    // power down must hold the rate controls it found; pixel pin keeps running
    pixel_tick_gen_i <= 1;
    wr(8'h04, 8'h00);
    wr(8'h01, 8'h03);
    repeat (3) @(posedge clock_i);
    chk(pd_view, 8'hCF);
    wr(8'h01, 8'h8E);
    repeat (3) @(posedge clock_i);
    chk(pd_view, 8'h43);
    wr(8'h01, 8'h2C);
    // general port driven then read, sync pins as inputs
    port_a_function_i <= 3'h7;
    port_a_direction_i <= 1;
    horizontal_sync_one_pin_i <= 1;
    vertical_sync_pin_i <= 1;
    wr(8'h04, 8'h05);
    repeat (6) @(posedge clock_i);
    chk({general_io_pin_o, general_io_pin_oe_o,
         horizontal_sync_one_pin_oe_o, hs1_in_o, vs_in_o, hphase_from_hs1_o, 2'b00}, 8'hDC);
    port_a_direction_i <= 0;
    general_io_pin_i <= 1;
    wr(8'h04, 8'h04);
    repeat (6) @(posedge clock_i);
    rd(8'h04, 8'h05);
    general_io_pin_i <= 0;
    repeat (6) @(posedge clock_i);
    rd(8'h04, 8'h04);
    chk({7'h00, general_io_pin_oe_o}, 8'h00);
    // gain register: live while running, held and writable when frozen
    live_gain_i <= 8'h3C;
    wr(8'h02, 8'h20);
    repeat (3) @(posedge clock_i);
    rd(8'h0B, 8'h3C);
    chk(gain_value_o, 8'h3C);
    wr(8'h02, 8'h30);
    repeat (3) @(posedge clock_i);
    live_gain_i <= 8'hC3;
    repeat (3) @(posedge clock_i);
    rd(8'h0B, 8'h3C);
    chk(gain_value_o, 8'h3C);
    wr(8'h0B, 8'h5A);
    repeat (3) @(posedge clock_i);
    rd(8'h0B, 8'h5A);
    chk(gain_value_o, 8'h5A);
    repeat (3) @(posedge clock_i);
    wrap_up();
  end
endmodule

`default_nettype wire
